// [logic/pdio_pkg.sv]
// Purpose: shared constants and types of the discrete i/o control block
// Assumes: apb with 32-bit data, 25 MHz core clock
// Notes: relay level 1 means contact closed
`default_nettype none
package pdio_pkg;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS     = 8'h00;
  localparam logic [7:0] INSEL_OFS    = 8'h04;
  localparam logic [7:0] OUTSEL_OFS   = 8'h08;
  localparam logic [7:0] STAT_OFS     = 8'h0c;
  // control register fields
  localparam int CTRL_LOC_LSB  = 0;   // control location, 3 bits
  localparam int CTRL_PER_LSB  = 8;   // sample period in ms, 7 bits
  localparam int CTRL_VENT_LSB = 16;  // stop hold ticks before vent, 8 bits
  // reset values
  localparam logic [2:0] LOC_RST    = 3'h0;  // local only
  localparam logic [6:0] PER_RST    = 7'h0a;
  localparam logic [7:0] VENT_RST   = 8'h32;
  localparam logic [11:0] INSEL_RST = 12'h000;
  localparam logic [15:0] OUTSEL_RST = 16'h0000;
  // timing
  localparam int CLK_HZ     = 25000000;
  localparam int MS_UNIT    = 1;        // one millisecond base step
  localparam int MS_CYCLES  = CLK_HZ / 1000 * MS_UNIT;
  localparam logic [6:0] PER_MIN_MS = 7'h0a;  // 10 ms
  localparam logic [6:0] PER_MAX_MS = 7'h64;  // 100 ms
  // counts of pins
  localparam int N_IN  = 3;
  localparam int N_OUT = 4;
  // control location settings
  typedef enum logic [2:0] {
    LOC_LOCAL, LOC_PLC, LOC_SERIAL, LOC_ALL, LOC_LOCAL_PLC, LOC_LOCAL_SERIAL
  } pdio_loc_t;
  // input function codes
  localparam logic [3:0] IF_NONE = 4'h0, IF_ZERO = 4'h1, IF_START = 4'h2, IF_STOP = 4'h3;
  localparam logic [3:0] IF_PURGE = 4'h4, IF_CLEAR = 4'h5, IF_CAL = 4'h6;
  localparam logic [3:0] IF_CALINT = 4'h7, IF_CALEXT = 4'h8;
  // output function codes
  localparam logic [3:0] OF_OPEN = 4'h0, OF_CLOSE = 4'h1, OF_TRIG1 = 4'h2, OF_ZERO = 4'h3;
  localparam logic [3:0] OF_READY = 4'h4, OF_CALACT = 4'h5, OF_CALREQ = 4'h6;
  localparam logic [3:0] OF_FAIL = 4'h7, OF_WARN = 4'h8, OF_GASB = 4'h9, OF_RECSTB = 4'ha;
  localparam logic [3:0] OF_PUMP = 4'hb, OF_STBY = 4'hc, OF_VENTED = 4'hd, OF_EMIS = 4'he;
  // instrument condition from the core
  typedef struct packed {
    logic thr1_exceeded;
    logic zero_running;
    logic emission_on;
    logic error_shown;
    logic warning_shown;
    logic cal_running;
    logic cal_request;
    logic ext_cal_running;
    logic gas_ballast;
    logic rec_invalid;
    logic rec_leak_rate;
    logic pumping_down;
    logic standby;
    logic vented;
  } pdio_cond_t;
  // command pulses to the core
  typedef struct packed {
    logic zero_on;
    logic zero_off;
    logic start;
    logic stop;
    logic vent;
    logic purge_on;
    logic purge_off;
    logic clear_err;
    logic cal_int;
    logic cal_ext;
    logic cal_confirm;
  } pdio_cmd_t;
endpackage : pdio_pkg
`default_nettype wire

// [logic/pdio_top.sv]
// Purpose: controller input edge commands and relay status outputs
// Assumes: inputs synchronous to CORE_CLK, apb slave with zero wait states
// Notes: relay bit 1 = contact closed, 0 = open
`timescale 1ns/10ps
`default_nettype none

// Contract
// - trigger one open on threshold or not measuring
// - zero relay closed while nulling runs
// - ready closed when emission on, no error
// - cal active closed while calibration runs
// - cal request opens on calibration request
// - fail and warning open when shown
// - gas ballast relay closed while active
// - fixed open and fixed closed selections
// - recorder strobe closed when value invalid and leak rate shown
// - pump down relay open while evacuating
// - standby open in standby/vent; vented in vent
// - emission relay open while emission on
// - inputs ignored unless location admits controller
// - zero input edges switch nulling on/off
// - start input rising edge starts
// - stop rising stops; long high also vents
// - purge input edges switch purge on/off
// - clear rising edge acknowledges error
// - cal rising: internal standby, external measuring
// - cal falling in external cal confirms
// - internal cal input rising always starts
// - external cal input rising starts, falling confirms
// - sample period programmable 10 to 100 ms
module pdio_top #(
  parameter int MS_CNT = pdio_pkg::MS_CYCLES  // cycles per millisecond
) (
  // clock and reset
  input  wire  logic                 CORE_CLK,
  input  wire  logic                 RST_N,
  // apb slave
  input  wire  logic                 PSEL,
  input  wire  logic                 PENABLE,
  input  wire  logic                 PWRITE,
  input  wire  logic [7:0]           PADDR,
  input  wire  logic [31:0]          PWDATA,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // controller inputs and instrument condition
  input  wire  logic [2:0]           PLC_IN,
  input  wire  pdio_pkg::pdio_cond_t COND,
  // command pulses and relay contacts
  output pdio_pkg::pdio_cmd_t        CMD,
  output logic [3:0]                 RELAY_CLOSED
);
  import pdio_pkg::*;

  // configuration registers
  logic [2:0]  loc_ff;        // control location
  logic [6:0]  per_ff;        // sample period, ms
  logic [7:0]  vent_ff;       // stop hold before vent, ticks
  logic [11:0] insel_ff;      // 4 bits per input
  logic [15:0] outsel_ff;     // 4 bits per relay
  logic [31:0] prdata_ff;     // read data
  logic        slverr_ff;     // unmapped flag
  // sampling state
  logic [14:0] ms_cnt_ff;     // cycles inside one ms
  logic [6:0]  per_cnt_ff;    // ms inside one period
  logic        tick_ff;       // sample taken this cycle
  logic [2:0]  samp_ff;       // current sample
  logic [2:0]  prev_ff;       // previous sample
  logic [7:0]  stop_cnt_ff;   // ticks stop held high
  logic        vent_done_ff;  // vent already issued this hold
  pdio_cmd_t   cmd_ff;        // command pulses
  logic [3:0]  relay_ff;      // contact states

  // clamp of the programmed period into the legal range
  function automatic logic [6:0] clamp_per(input logic [6:0] p);
    if (p < PER_MIN_MS) begin
      return PER_MIN_MS;
    end
    if (p > PER_MAX_MS) begin
      return PER_MAX_MS;
    end
    return p;
  endfunction : clamp_per

  // contact state for one output function code
  function automatic logic relay_level(input logic [3:0] f, input pdio_cond_t c);
    logic ready;
    ready = c.emission_on & ~c.error_shown;
    unique case (f)
      OF_OPEN:   return 1'b0;
      OF_CLOSE:  return 1'b1;
      OF_TRIG1:  return ~(c.thr1_exceeded | ~ready);
      OF_ZERO:   return c.zero_running;
      OF_READY:  return ready;
      OF_CALACT: return c.cal_running;
      OF_CALREQ: return ~c.cal_request;
      OF_FAIL:   return ~c.error_shown;
      OF_WARN:   return ~c.warning_shown;
      OF_GASB:   return c.gas_ballast;
      OF_RECSTB: return c.rec_invalid & c.rec_leak_rate;
      OF_PUMP:   return ~c.pumping_down;
      OF_STBY:   return ~(c.standby | c.vented);
      OF_VENTED: return ~c.vented;
      OF_EMIS:   return ~c.emission_on;
      default:   return 1'b0;                                 // unused code: open
    endcase
  endfunction : relay_level

  // apb decode
  wire        apb_setup = PSEL & ~PENABLE;
  wire        apb_wr    = PSEL & PENABLE & PWRITE;
  wire        hit_ctrl  = (PADDR == CTRL_OFS);
  wire        hit_insel = (PADDR == INSEL_OFS);
  wire        hit_outs  = (PADDR == OUTSEL_OFS);
  wire        hit_stat  = (PADDR == STAT_OFS);
  wire        hit_any   = hit_ctrl | hit_insel | hit_outs | hit_stat;
  wire [31:0] rd_mux    = hit_ctrl  ? {8'h00, vent_ff, 1'b0, per_ff, 5'h00, loc_ff} :
                          hit_insel ? {20'h00000, insel_ff} :
                          hit_outs  ? {16'h0000, outsel_ff} :
                          hit_stat  ? {21'h000000, relay_ff, 1'b0, prev_ff, samp_ff} :
                          32'h00000000;
  assign PREADY  = 1'b1;
  assign PRDATA  = prdata_ff;
  assign PSLVERR = PSEL & PENABLE & slverr_ff;

  // sample timing
  wire [6:0] per_eff  = clamp_per(per_ff);
  wire       ms_end   = (ms_cnt_ff == 15'(MS_CNT - 1));
  wire       per_end  = ms_end & (per_cnt_ff == per_eff - 7'h01);
  // location gate
  wire       loc_ok   = (loc_ff == LOC_PLC) | (loc_ff == LOC_ALL) |
                        (loc_ff == LOC_LOCAL_PLC);
  wire [2:0] rise     = samp_ff & ~prev_ff;
  wire [2:0] fall     = ~samp_ff & prev_ff;
  wire       ready_c  = COND.emission_on & ~COND.error_shown;

  // function code of each input
  wire [3:0] fsel [N_IN];
  genvar gi;
  for (gi = 0; gi < N_IN; gi++) begin : g_sel
    assign fsel[gi] = insel_ff[gi*4 +: 4];
  end

  // stop input held high from the last sample
  logic stop_hi;
  always_comb begin
    stop_hi = 1'b0;
    for (int i = 0; i < N_IN; i++) begin
      if (fsel[i] == IF_STOP && samp_ff[i]) begin
        stop_hi = 1'b1;
      end
    end
  end
  wire vent_due = tick_ff & stop_hi & ~vent_done_ff & (stop_cnt_ff >= vent_ff);

  // next command pulses, only in the cycle after a sample
  pdio_cmd_t nxt_cmd;
  always_comb begin
    nxt_cmd = '0;
    if (tick_ff && loc_ok) begin
      for (int i = 0; i < N_IN; i++) begin
        unique case (fsel[i])
          IF_ZERO: begin
            nxt_cmd.zero_on   |= rise[i];
            nxt_cmd.zero_off  |= fall[i];
          end
          IF_START: begin
            nxt_cmd.start     |= rise[i];
          end
          IF_STOP: begin
            nxt_cmd.stop      |= rise[i];
          end
          IF_PURGE: begin
            nxt_cmd.purge_on  |= rise[i];
            nxt_cmd.purge_off |= fall[i];
          end
          IF_CLEAR: begin
            nxt_cmd.clear_err |= rise[i];
          end
          IF_CAL: begin
            nxt_cmd.cal_int   |= rise[i] & COND.standby;
            nxt_cmd.cal_ext   |= rise[i] & ready_c;
            nxt_cmd.cal_confirm |= fall[i] & COND.ext_cal_running;
          end
          IF_CALINT: begin
            nxt_cmd.cal_int   |= rise[i];
          end
          IF_CALEXT: begin
            nxt_cmd.cal_ext   |= rise[i];
            nxt_cmd.cal_confirm |= fall[i];
          end
          default: begin
          end
        endcase
      end
      nxt_cmd.vent = vent_due;
    end
  end

  // next relay states
  logic [3:0] nxt_relay;
  always_comb begin
    for (int j = 0; j < N_OUT; j++) begin
      nxt_relay[j] = relay_level(outsel_ff[j*4 +: 4], COND);
    end
  end

  // register writes
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      loc_ff    <= LOC_RST;
      per_ff    <= PER_RST;
      vent_ff   <= VENT_RST;
      insel_ff  <= INSEL_RST;
      outsel_ff <= OUTSEL_RST;
    end else if (apb_wr) begin
      if (hit_ctrl) begin
        loc_ff  <= PWDATA[CTRL_LOC_LSB +: 3];
        per_ff  <= PWDATA[CTRL_PER_LSB +: 7];
        vent_ff <= PWDATA[CTRL_VENT_LSB +: 8];
      end
      if (hit_insel) begin
        insel_ff <= PWDATA[11:0];
      end
      if (hit_outs) begin
        outsel_ff <= PWDATA[15:0];
      end
    end
  end

  // read data captured in the setup cycle
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_ff <= 32'h00000000;
      slverr_ff <= 1'b0;
    end else if (apb_setup) begin
      prdata_ff <= rd_mux;
      slverr_ff <= ~hit_any;
    end
  end

  // millisecond and period counters
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ms_cnt_ff  <= 15'h0000;
      per_cnt_ff <= 7'h00;
    end else begin
      ms_cnt_ff  <= ms_end ? 15'h0000 : ms_cnt_ff + 15'h0001;
      if (per_end) begin
        per_cnt_ff <= 7'h00;
      end else if (ms_end) begin
        per_cnt_ff <= (per_cnt_ff >= per_eff) ? 7'h00 : per_cnt_ff + 7'h01;
      end
    end
  end

  // input sampling at the period
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_ff <= 1'b0;
      samp_ff <= 3'h0;
      prev_ff <= 3'h0;
    end else begin
      tick_ff <= per_end;
      if (per_end) begin
        samp_ff <= PLC_IN;
        prev_ff <= samp_ff;
      end
    end
  end

  // stop hold timer, one vent per hold
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stop_cnt_ff  <= 8'h00;
      vent_done_ff <= 1'b0;
    end else if (tick_ff) begin
      if (!stop_hi) begin
        stop_cnt_ff  <= 8'h00;
        vent_done_ff <= 1'b0;
      end else begin
        if (stop_cnt_ff != 8'hff) begin
          stop_cnt_ff <= stop_cnt_ff + 8'h01;
        end
        if (vent_due && loc_ok) begin
          vent_done_ff <= 1'b1;
        end
      end
    end
  end

  // output flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd_ff   <= '0;
      relay_ff <= 4'h0;
    end else begin
      cmd_ff   <= nxt_cmd;
      relay_ff <= nxt_relay;
    end
  end
  assign CMD          = cmd_ff;
  assign RELAY_CLOSED = relay_ff;

  // checks
  a_relay_fixed: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (outsel_ff[3:0] == OF_CLOSE) [*2] |-> RELAY_CLOSED[0])
    else $error("fixed closed relay not closed");
  a_relay_open: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (outsel_ff[3:0] == OF_OPEN) [*2] |-> !RELAY_CLOSED[0])
    else $error("fixed open relay not open");
  a_trig_open: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (outsel_ff[7:4] == OF_TRIG1 && COND.thr1_exceeded) |=> !RELAY_CLOSED[1])
    else $error("trigger relay closed above threshold");
  a_ready_follow: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (outsel_ff[7:4] == OF_READY) |=> RELAY_CLOSED[1] == $past(ready_c))
    else $error("ready relay wrong");
  a_stby_open: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (outsel_ff[11:8] == OF_STBY && COND.vented) |=> !RELAY_CLOSED[2])
    else $error("standby relay closed in vent");
  a_emis_open: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (outsel_ff[15:12] == OF_EMIS && COND.emission_on) |=> !RELAY_CLOSED[3])
    else $error("emission relay closed while emission on");
  a_loc_gate: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !loc_ok |=> CMD == '0)
    else $error("command issued with controller locked out");
  a_cmd_tick: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    CMD != '0 |-> $past(tick_ff))
    else $error("command outside sample tick");
  a_start_rise: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    (tick_ff && loc_ok && fsel[1] == IF_START && rise[1]) |=> CMD.start)
    else $error("start edge lost");
  a_per_range: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    per_eff >= PER_MIN_MS && per_eff <= PER_MAX_MS)
    else $error("sample period out of range");
endmodule : pdio_top
`default_nettype wire

// [testbench/pdio_plc_model.sv]
// Purpose: controller side model that drives the three input pins
// Assumes: levels change only just after a rising clock edge
// Notes: a level is held until the next request, so every step is sampled
`timescale 1ns/10ps
`default_nettype none
module pdio_plc_model (
  // clock
  input  wire logic clk,
  // input levels to the block
  output logic [2:0] pins
);
  // all pins low from time zero
  initial pins = 3'h0;

  // one pin changes right after an edge and then stands
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
  endtask : set_pin
endmodule : pdio_plc_model
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench of the discrete i/o control block
// Assumes: 4 cycles per ms, so a 10 ms sample is 40 cycles
// Notes: relay 1 = closed; pulses are read 1 ns after each edge
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import pdio_pkg::*;
  localparam int MSC = 4;        // cycles per ms in sim
  localparam int LIMIT = 20000;  // timeout in cycles
  localparam int WT = 48;        // one 10 ms sample plus margin
  localparam int ZON = 10, ZOF = 9, STA = 8, STO = 7, VNT = 6;  // pulse bits
  // bench signals
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [2:0] pins;
  pdio_cond_t cond = '0;
  pdio_cmd_t cmd;
  logic [3:0] relay;
  int cyc = 0, error_cnt = 0, tests_run = 0;
  logic ok;
  // condition patterns for the relay sweep
  logic [13:0] conds [6] = '{14'h0, 14'h3fff, 14'h800, 14'h2810, 14'h2, 14'h1};
  // input code, condition, pulses on rise and on fall
  logic [3:0] row_code [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h6, 4'h6, 4'h7, 4'h8};
  logic [13:0] row_cond [8] = '{14'h0, 14'h0, 14'h0, 14'h2, 14'h840, 14'hc00, 14'h800, 14'h2};
  logic [10:0] row_rise [8] = '{11'h0, 11'h20, 11'h8, 11'h4, 11'h2, 11'h0, 11'h4, 11'h2};
  logic [10:0] row_fall [8] = '{11'h0, 11'h10, 11'h0, 11'h0, 11'h1, 11'h0, 11'h0, 11'h1};

  // device under test with a short millisecond
  pdio_top #(.MS_CNT(MSC)) u_dut (
    .CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PLC_IN(pins), .COND(cond),
    .CMD(cmd), .RELAY_CLOSED(relay)
  );
  // controller model
  pdio_plc_model u_plc (.clk(core_clk), .pins(pins));

  // 25 MHz clock
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  // cycle count and hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      print_verdict();
    end
  end

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // closing report
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // one apb transfer, answer taken at the ready edge
  task automatic apb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] r, output logic e);
    logic rdy;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // request stands until the edge that sees pready; answer taken at that edge
    do begin
      @(posedge core_clk);
      rdy = pready;
      r = prdata;
      e = pslverr;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    check(rdy, 1'b1);
  endtask : apb_xfer
  task automatic apb_wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, r, e);
  endtask : apb_wr
  task automatic apb_rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b0, a, 32'h0, r, e);
    check(r, x);
    check(e, xe);
  endtask : apb_rd
  // control word: stop hold 2 ticks, period, location
  function automatic logic [31:0] ctrl_word(input logic [2:0] l, input logic [6:0] p);
    ctrl_word = {8'h0, 8'h02, 1'b0, p, 5'h0, l};
  endfunction : ctrl_word
  function automatic logic [10:0] one(input int b);
    one = 11'h1 << b;
  endfunction : one
  // expected contact for a function code
  function automatic logic rly(input logic [3:0] f, input pdio_cond_t c);
    logic rdy;
    rdy = c.emission_on & ~c.error_shown;
    case (f)
      OF_CLOSE: rly = 1'b1;
      OF_TRIG1: rly = rdy & ~c.thr1_exceeded;
      OF_ZERO: rly = c.zero_running;
      OF_READY: rly = rdy;
      OF_CALACT: rly = c.cal_running;
      OF_CALREQ: rly = ~c.cal_request;
      OF_FAIL: rly = ~c.error_shown;
      OF_WARN: rly = ~c.warning_shown;
      OF_GASB: rly = c.gas_ballast;
      OF_RECSTB: rly = c.rec_invalid & c.rec_leak_rate;
      OF_PUMP: rly = ~c.pumping_down;
      OF_STBY: rly = ~(c.standby | c.vented);
      OF_VENTED: rly = ~c.vented;
      OF_EMIS: rly = ~c.emission_on;
      default: rly = 1'b0;
    endcase
  endfunction : rly
  // move one pin, gather the pulses that follow
  task automatic pin_step(input int idx, input logic v, input logic [10:0] x,
                          input int n, input int w);
    logic [10:0] seen;
    int cnt;
    seen = 11'h0;
    cnt = 0;
    u_plc.set_pin(idx, v);
    repeat (w) begin
      @(posedge core_clk);
      #1;
      seen = seen | cmd;
      cnt += $countones(cmd);
    end
    check(seen, x);
    check(cnt, n);
  endtask : pin_step
  // wait for one pulse bit, bounded
  task automatic wait_cmd(input int b);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      #1;
      n++;
    end while (cmd[b] !== 1'b1 && n < 1000);
    check(cmd[b], 1'b1);
  endtask : wait_cmd
  // cycles between two samples at a given period
  task automatic meas(input logic [6:0] per, input int xc);
    int t0;
    apb_wr(CTRL_OFS, ctrl_word(3'h1, per));
    u_plc.set_pin(0, 1'b1);
    wait_cmd(ZON);
    t0 = cyc;
    u_plc.set_pin(0, 1'b0);
    wait_cmd(ZOF);
    check(cyc - t0, xc);
  endtask : meas

  // main sequence
  initial begin
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    // defaults and an unmapped address
    apb_rd(CTRL_OFS, {8'h0, VENT_RST, 1'b0, PER_RST, 5'h0, LOC_RST}, 1'b0);
    apb_rd(INSEL_OFS, {20'h0, INSEL_RST}, 1'b0);
    apb_rd(OUTSEL_OFS, {16'h0, OUTSEL_RST}, 1'b0);
    apb_rd(8'h10, 32'h0, 1'b1);
    // every relay function under several conditions
    for (int k = 0; k < 6; k++) begin
      cond <= conds[k];
      for (int f = 0; f < 16; f++) begin
        apb_wr(OUTSEL_OFS, {16'h0, {4{4'(f)}}});
        repeat (3) @(posedge core_clk);
        check(relay, {4{rly(4'(f), cond)}});
      end
    end
    // independent selects per relay
    apb_wr(OUTSEL_OFS, 32'h1010);
    repeat (3) @(posedge core_clk);
    check(relay, 4'ha);
    apb_xfer(1'b0, STAT_OFS, 32'h0, r, e);
    check(r[10:7], 4'ha);
    // location setting gates the inputs
    apb_wr(INSEL_OFS, 32'h321);
    for (int l = 0; l < 6; l++) begin
      apb_wr(CTRL_OFS, ctrl_word(3'(l), 7'h0a));
      ok = (l == 1) || (l == 3) || (l == 4);
      pin_step(0, 1'b1, ok ? one(ZON) : 11'h0, int'(ok), WT);
      pin_step(0, 1'b0, ok ? one(ZOF) : 11'h0, int'(ok), WT);
    end
    // start and stop on their own pins
    apb_wr(CTRL_OFS, ctrl_word(3'h1, 7'h0a));
    pin_step(1, 1'b1, one(STA), 1, WT);
    pin_step(1, 1'b0, 11'h0, 0, WT);
    pin_step(2, 1'b1, one(STO) | one(VNT), 2, 5 * WT);
    pin_step(2, 1'b0, 11'h0, 0, WT);
    // remaining input codes on pin 0
    for (int i = 0; i < 8; i++) begin
      apb_wr(INSEL_OFS, {20'h0, 8'h32, row_code[i]});
      cond <= row_cond[i];
      pin_step(0, 1'b1, row_rise[i], $countones(row_rise[i]), WT);
      pin_step(0, 1'b0, row_fall[i], $countones(row_fall[i]), WT);
    end
    // sample period, clamped at both ends
    apb_wr(INSEL_OFS, 32'h321);
    cond <= '0;
    meas(7'h0a, 10 * MSC);
    meas(7'h05, 10 * MSC);
    meas(7'h64, 100 * MSC);
    meas(7'h7f, 100 * MSC);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
